// ### hw/cswt_top.sv
// Cyclic sense and wake timers with their control register
module cswt_top (
  input  wire logic                    clk,
  input  wire logic                    rst,
  input  wire logic                    soft_reset,
  input  wire logic                    restart,
  input  wire logic                    hs_assign_t1,
  input  wire logic                    hs_assign_t2,
  input  wire logic                    hs_cleared,
  input  wire logic                    fail_safe,
  input  wire logic                    wr_en,
  input  wire logic                    rd_en,
  input  wire logic [6:0]              addr,
  input  wire logic [15:0]             wdata,
  input  wire cswt_pkg::cswt_wake_cfg_t wake_cfg,
  output logic [15:0]                  rdata,
  output logic                         rvalid,
  output logic [1:0]                   high_side_output,
  output logic                         wake_request,
  output logic                         filter_sample,
  output logic [6:0]                   filter_us,
  output logic                         wake_fs_force,
  output logic [1:0]                   wake_input_enable,
  output logic                         sync_enable
);
  cswt_pkg::cswt_ctrl_t    ctrl;
  cswt_pkg::cswt_ctrl_t    next_ctrl;
  cswt_pkg::cswt_tmr_out_t t1_out;
  cswt_pkg::cswt_tmr_out_t t2_out;
  logic [7:0]              tick_div;
  logic                    tick;
  logic                    fs_q;

  // Register decode
  wire sel      = addr == cswt_pkg::TIMER_ADDR;
  wire wr_hit   = wr_en && sel;
  wire [15:0] w_masked = wdata & cswt_pkg::TIMER_WMASK;
  wire clr_t1   = restart && hs_cleared && hs_assign_t1;
  wire clr_t2   = restart && hs_cleared && hs_assign_t2;

  // Next register value; Restart with a cleared switch wipes only that timer
  always_comb begin
    next_ctrl = ctrl;
    if (wr_hit) begin
      next_ctrl = cswt_pkg::cswt_ctrl_t'(w_masked);
    end
    if (clr_t1) begin
      next_ctrl.t1_on  = 3'h0;
      next_ctrl.t1_per = 3'h0;
    end
    if (clr_t2) begin
      next_ctrl.t2_on  = 3'h0;
      next_ctrl.t2_per = 3'h0;
    end
    next_ctrl.res12 = 1'b0;
    next_ctrl.res3  = 1'b0;
  end

  // Control register; soft reset returns every field to zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl <= cswt_pkg::cswt_ctrl_t'(cswt_pkg::TIMER_RESET);
    end else if (soft_reset) begin
      ctrl <= cswt_pkg::cswt_ctrl_t'(cswt_pkg::TIMER_RESET);
    end else begin
      ctrl <= next_ctrl;
    end
  end

  // Read port answers one cycle later; unmapped reads give zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata  <= 16'h0000;
      rvalid <= 1'b0;
    end else begin
      rvalid <= rd_en;
      rdata  <= (rd_en && sel) ? ctrl : 16'h0000;
    end
  end

  // Microsecond tick from the oscillator clock
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tick_div <= 8'h00;
      tick     <= 1'b0;
    end else begin
      tick     <= tick_div == 8'(cswt_pkg::TICK_CYC - 1);
      tick_div <= (tick_div == 8'(cswt_pkg::TICK_CYC - 1)) ? 8'h00 : tick_div + 8'h01;
    end
  end

  cswt_timer u_t1 (
    .clk      (clk),
    .rst      (rst),
    .tick     (tick),
    .on_code  (ctrl.t1_on),
    .per_code (ctrl.t1_per),
    .restart  (restart),
    .tout     (t1_out)
  );

  cswt_timer u_t2 (
    .clk      (clk),
    .rst      (rst),
    .tick     (tick),
    .on_code  (ctrl.t2_on),
    .per_code (ctrl.t2_per),
    .restart  (restart),
    .tout     (t2_out)
  );

  // Wake source; sensing keeps running alongside, reserved 11 wakes nothing
  wire wake_hit = ((ctrl.cyclic_wake_source_select == 2'h1) && t1_out.wake_event) ||
                  ((ctrl.cyclic_wake_source_select == 2'h2) && t2_out.wake_event);

  // Filter selection; Fail-Safe overrides it with static 16 us
  wire bank4    = wake_cfg.wake_bank_select == cswt_pkg::BANK_FOUR;
  wire sync_ok  = bank4 && (wake_cfg.wake_input_enable == cswt_pkg::WK_SYNC) && !fail_safe;
  wire f_t1     = wake_cfg.wake_filter_select == cswt_pkg::FILT_T1;
  wire f_t2     = wake_cfg.wake_filter_select == cswt_pkg::FILT_T2;
  wire f_64     = wake_cfg.wake_filter_select == cswt_pkg::FILT_64;
  wire strobe   = fail_safe ? 1'b0 :
                  (f_t1 && t1_out.filt_strobe) || (f_t2 && t2_out.filt_strobe);
  wire [6:0] f_time = (fail_safe || !f_64) ? 7'(cswt_pkg::FILT_US) : 7'(cswt_pkg::FILT64_US);

  // Output registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      high_side_output  <= 2'b00;
      wake_request      <= 1'b0;
      filter_sample     <= 1'b0;
      filter_us         <= 7'h00;
      wake_fs_force     <= 1'b0;
      wake_input_enable <= 2'b00;
      sync_enable       <= 1'b0;
      fs_q              <= 1'b0;
    end else begin
      fs_q              <= fail_safe;
      high_side_output  <= {t2_out.sense_on, t1_out.sense_on};
      wake_request      <= wake_hit;
      filter_sample     <= strobe;
      filter_us         <= f_time;
      wake_fs_force     <= fail_safe && !fs_q;
      wake_input_enable <= fail_safe ? cswt_pkg::WK_ON : wake_cfg.wake_input_enable;
      sync_enable       <= sync_ok;
    end
  end
endmodule

// ### pkg/cswt_pkg.sv
// Package of constants and types for the cyclic sense and wake timers
// Function
// - 3-bit on-time; 000 stops timer, output low; 001-101 select 0.1/0.3/1/10/20 ms.
// - On-time 110 stops timer with output high; 111 behaves as 110.
// - 3-bit period; 10,20,50,100,200,500 ms, 1 s and 2 s.
// - Cyclic wake field: 00 none, 01 timer one, 10 timer two, 11 reserved.
// - Assigned timer starts by itself once a running on-time is written.
// - Restart clearing an assigned switch clears that timer's period and on-time.
// - Wake source and cyclic sense on one timer run together.
// - Fail-Safe entry forces wake input enable to 01, overriding sync.
// - In Fail-Safe, filter selection ignored; static 16 us filter used.
// - Sync function of wake input only when wake bank 4 selected.
// - Bits 12 and 3 read zero, writes ignored.
// - Filter codes 010/011 filter 16 us at end of timer one/two on-time.
// - Wake enable 10 makes wake input four a sync input, else off.
package cswt_pkg;
  localparam int unsigned CLK_HZ      = 200_000_000;
  localparam logic [6:0]  TIMER_ADDR  = 7'h06;
  localparam logic [15:0] TIMER_RESET = 16'h0000;
  localparam logic [15:0] TIMER_WMASK = 16'hefff & 16'hfff7;
  localparam int unsigned T2_ON_LSB   = 13;
  localparam int unsigned T2_PER_LSB  = 9;
  localparam int unsigned CYCLIC_WAKE_SOURCE_SELECT_LSB   = 7;
  localparam int unsigned T1_ON_LSB   = 4;
  localparam int unsigned T1_PER_LSB  = 0;
  // Microsecond tick base for all timer counts
  localparam int unsigned TICK_US     = 1;
  localparam int unsigned TICK_CYC    = CLK_HZ / 1_000_000 * TICK_US;
  localparam int unsigned FILT_US     = 16;
  localparam int unsigned FILT64_US   = 64;
  localparam int unsigned SETTLE_US   = 80;
  localparam logic [2:0]  ON_OFF_LOW  = 3'h0;
  localparam logic [2:0]  ON_OFF_HIGH = 3'h6;
  localparam logic [1:0]  WK_ON       = 2'h1;
  localparam logic [1:0]  WK_SYNC     = 2'h2;
  localparam logic [2:0]  BANK_FOUR   = 3'h3;
  localparam logic [2:0]  FILT_T1     = 3'h2;
  localparam logic [2:0]  FILT_T2     = 3'h3;
  localparam logic [2:0]  FILT_SYNC   = 3'h4;
  localparam logic [2:0]  FILT_64     = 3'h1;

  typedef struct packed {
    logic [2:0] t2_on;
    logic       res12;
    logic [2:0] t2_per;
    logic [1:0] cyclic_wake_source_select;
    logic [2:0] t1_on;
    logic       res3;
    logic [2:0] t1_per;
  } cswt_ctrl_t;

  typedef struct packed {
    logic [2:0] wake_filter_select;
    logic [1:0] wake_input_enable;
    logic [2:0] wake_bank_select;
  } cswt_wake_cfg_t;

  typedef struct packed {
    logic       sense_on;
    logic       filt_strobe;
    logic       wake_event;
  } cswt_tmr_out_t;

  // On-time in microseconds per code
  function automatic logic [14:0] cswt_on_us(input logic [2:0] code);
    unique case (code)
      3'h1:    return 15'd100;
      3'h2:    return 15'd300;
      3'h3:    return 15'd1000;
      3'h4:    return 15'd10000;
      3'h5:    return 15'd20000;
      default: return 15'd0;
    endcase
  endfunction

  // Period in microseconds per code
  function automatic logic [21:0] cswt_per_us(input logic [2:0] code);
    unique case (code)
      3'h0:    return 22'd10000;
      3'h1:    return 22'd20000;
      3'h2:    return 22'd50000;
      3'h3:    return 22'd100000;
      3'h4:    return 22'd200000;
      3'h5:    return 22'd500000;
      3'h6:    return 22'd1000000;
      default: return 22'd2000000;
    endcase
  endfunction
endpackage

// ### hw/cswt_timer.sv
// One cyclic period/on-time timer counting microsecond ticks
module cswt_timer (
  input  wire logic                    clk,
  input  wire logic                    rst,
  input  wire logic                    tick,
  input  wire logic [2:0]              on_code,
  input  wire logic [2:0]              per_code,
  input  wire logic                    restart,
  output cswt_pkg::cswt_tmr_out_t      tout
);
  logic [21:0] cnt;
  logic [2:0]  on_q;
  logic [2:0]  per_q;
  wire         running   = (on_code != cswt_pkg::ON_OFF_LOW) && (on_code < cswt_pkg::ON_OFF_HIGH);
  wire         held_high = on_code >= cswt_pkg::ON_OFF_HIGH;
  wire [21:0]  on_len    = {7'h00, cswt_pkg::cswt_on_us(on_code)};
  wire [21:0]  per_len   = cswt_pkg::cswt_per_us(per_code);
  wire         cfg_chg   = (on_code != on_q) || (per_code != per_q);
  wire         last      = cnt >= per_len - 22'h000001;

  // Period counter restarts on any new setting, so a written on-time starts at once
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt  <= 22'h000000;
      on_q <= 3'h0;
      per_q <= 3'h0;
      tout <= '0;
    end else begin
      on_q  <= on_code;
      per_q <= per_code;
      if (restart || !running || cfg_chg) begin
        cnt <= 22'h000000;
      end else if (tick) begin
        cnt <= last ? 22'h000000 : cnt + 22'h000001;
      end
      tout.sense_on    <= held_high || (running && !restart && cnt < on_len);
      tout.filt_strobe <= running && tick && (cnt == on_len - 22'h000001);
      tout.wake_event  <= running && tick && last;
    end
  end
endmodule

// ### tb/cswt_props.sv
// Concurrent checks on the ports of the timer block
module cswt_props (
  input wire logic                     clk,
  input wire logic                     rst,
  input wire logic                     restart,
  input wire logic                     soft_reset,
  input wire logic                     fail_safe,
  input wire logic                     wr_en,
  input wire logic                     rd_en,
  input wire logic [6:0]               addr,
  input wire logic [15:0]              wdata,
  input wire cswt_pkg::cswt_wake_cfg_t wake_cfg,
  input wire logic [15:0]              rdata,
  input wire logic                     rvalid,
  input wire logic [1:0]               high_side_output,
  input wire logic                     filter_sample,
  input wire logic [6:0]               filter_us,
  input wire logic                     wake_fs_force,
  input wire logic [1:0]               wake_input_enable,
  input wire logic                     sync_enable
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Quiet cycles let a stopped code reach the pin
  wire quiet = !(wr_en || restart || soft_reset);
  wire t1_wr = wr_en && addr == cswt_pkg::TIMER_ADDR && !restart && !soft_reset;
  a_off_high_hold: assert property (t1_wr && wdata[6:5] == 2'h3 ##1 quiet [*4] |-> high_side_output[0])
    else $error("timer one off-high code did not hold output high");
  a_off_low_hold: assert property (t1_wr && wdata[6:4] == 3'h0 ##1 quiet [*4] |-> !high_side_output[0])
    else $error("timer one off-low code did not hold output low");
  a_reserved_read_zero: assert property (rd_en |=> rvalid && !rdata[12] && !rdata[3])
    else $error("read answer missing or reserved bits set");
  a_fs_enable_forced: assert property (fail_safe |=> wake_input_enable == 2'h1)
    else $error("wake enable not forced in fail-safe");
  a_fs_entry_pulse: assert property ($rose(fail_safe) |=> wake_fs_force)
    else $error("no force pulse on fail-safe entry");
  a_fs_static_filter: assert property (fail_safe |=> filter_us == 7'h10 && !filter_sample)
    else $error("fail-safe filter not static");
  a_sync_bank_only: assert property (sync_enable |-> $past(wake_cfg.wake_bank_select) == 3'h3
    && $past(wake_cfg.wake_input_enable) == 2'h2 && !$past(fail_safe))
    else $error("sync enabled outside bank four sync setup");
  a_filter_cause: assert property (filter_sample |-> $past(wake_cfg.wake_filter_select[2:1]) == 2'h1)
    else $error("filter sample without timer filter code");
  c_read: cover property (rvalid);
  c_sync: cover property (sync_enable);
  c_filter: cover property (filter_sample);
  c_fs_entry: cover property (wake_fs_force);
endmodule

bind cswt_top cswt_props u_props (.*);

// ### tb/cswt_load.sv
// Load model on high-side output bit 0 (timer one) that times each on-phase
module cswt_load (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [1:0] high_side_output,
  output logic     [15:0] on_len
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] run;
  // Keeps the last finished high phase; an unfinished one is not reported
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      run <= 16'h0;
      on_len <= 16'h0;
    end else if (high_side_output[0]) begin
      run <= run + 16'h1;
    end else begin
      if (run != 16'h0) on_len <= run;
      run <= 16'h0;
    end
  end
endmodule

// ### tb/tb_top.sv
// Self-checking bench for the cyclic sense and wake timers
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic                     clk, rst, soft_reset, restart, hs_assign_t1, hs_assign_t2;
  logic                     hs_cleared, fail_safe, wr_en, rd_en, rvalid, wake_request;
  logic                     filter_sample, wake_fs_force, sync_enable;
  logic [6:0]               addr, filter_us;
  logic [15:0]              wdata, rdata, on_len, v, w;
  logic [1:0]               high_side_output, wake_input_enable;
  cswt_pkg::cswt_wake_cfg_t wake_cfg;
  int                       num_errors, total_checks, seed, n, k, m;
  cswt_top uut (.*);
  cswt_load u_load (.clk(clk), .rst(rst), .high_side_output(high_side_output), .on_len(on_len));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Readback keeps only writable bits
  function automatic logic [15:0] kept(input logic [15:0] x);
    return x & 16'heff7;
  endfunction
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic conclude();
    if (num_errors == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    addr = a;
    wdata = d;
    wr_en = 1'b1;
    @(negedge clk);
    wr_en = 1'b0;
  endtask
  // Answer lands one cycle after the request; poll up to four more edges before failing
  task automatic rd(input logic [6:0] a, output logic [15:0] d);
    addr = a;
    rd_en = 1'b1;
    @(negedge clk);
    rd_en = 1'b0;
    n = 0;
    while (rvalid !== 1'b1 && n < 4) begin
      @(negedge clk);
      n++;
    end
    if (n == 4) begin
      num_errors++;
      conclude();
    end
    d = rdata;
    @(negedge clk);
  endtask
  initial begin
    {soft_reset, restart, hs_assign_t1, hs_assign_t2, hs_cleared, fail_safe, wr_en, rd_en, addr, wdata} = '0;
    wake_cfg = '0;
    seed = 95176;
    rst = 1'b1;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    rd(7'h06, v);
    chk("ctrl_reset", 16'h0000, v);
    rd(7'h15, v);
    chk("unmapped_read", 16'h0000, v);
    hs_assign_t1 = 1'b1;
    // All-ones corner first, then random words
    for (int i = 0; i < 8; i++) begin
      w = (i == 0) ? 16'hffff : 16'($random(seed));
      wr(7'h06, w);
      rd(7'h06, v);
      chk("ctrl_readback", kept(w), v);
      // Quiet gap so the stopped-code checks see the pin settle
      repeat (4) @(negedge clk);
    end
    // Timer one runs 100 us and is the wake source, timer two held high
    wake_cfg.wake_filter_select = 3'h2;
    wr(7'h06, 16'h0000);
    repeat (10) @(negedge clk);
    wr(7'h06, 16'hc090);
    k = 0;
    m = 0;
    repeat (21000) begin
      @(negedge clk);
      k += int'(filter_sample);
      m += int'(wake_request);
    end
    chk("filter_pulses", 16'h1, 16'(k));
    // A 10 ms period cannot wake within the first on-phase
    chk("early_wake", 16'h0, 16'(m));
    chk("on_time_ok", 16'h1, 16'(on_len > 16'd19600 && on_len < 16'd20400));
    chk("t2_off_high", 16'h2, 16'(high_side_output));
    // Restart without, then with, a cleared switch
    wr(7'h06, 16'h6dd5);
    restart = 1'b1;
    repeat (3) @(negedge clk);
    restart = 1'b0;
    rd(7'h06, v);
    chk("restart_keep", 16'h6dd5, v);
    restart = 1'b1;
    hs_cleared = 1'b1;
    repeat (3) @(negedge clk);
    hs_assign_t1 = 1'b0;
    hs_assign_t2 = 1'b1;
    repeat (3) @(negedge clk);
    {restart, hs_cleared} = 2'h0;
    rd(7'h06, v);
    chk("restart_clear", 16'h0180, v);
    soft_reset = 1'b1;
    @(negedge clk);
    soft_reset = 1'b0;
    rd(7'h06, v);
    chk("soft_reset", 16'h0000, v);
    // Sync setup, then fail-safe overriding it
    wake_cfg = '{3'h1, 2'h2, 3'h3};
    repeat (3) @(negedge clk);
    chk("sync_on", 16'h1, 16'(sync_enable));
    chk("filter_64", 16'h40, 16'(filter_us));
    fail_safe = 1'b1;
    k = 0;
    repeat (3) begin
      @(negedge clk);
      k += int'(wake_fs_force);
    end
    chk("fs_force_pulse", 16'h1, 16'(k));
    chk("fs_enable", 16'h1, 16'(wake_input_enable));
    chk("fs_filter", 16'h10, 16'(filter_us));
    chk("fs_sync", 16'h0, 16'(sync_enable));
    fail_safe = 1'b0;
    wake_cfg.wake_bank_select = 3'h0;
    repeat (3) @(negedge clk);
    chk("sync_other_bank", 16'h0, 16'(sync_enable));
    chk("enable_follow", 16'h2, 16'(wake_input_enable));
    conclude();
  end
endmodule
